// ### logic/acfg_pkg.sv
// Constants for the converter configuration register bank.
package acfg_pkg;

   // ---------------------------------------------------------------
   // Address map
   // ---------------------------------------------------------------
   localparam int          AW            = 13;
   localparam logic [12:0] ADDR_PORT_CFG = 13'h000;
   localparam logic [12:0] ADDR_CHIP_IDENTIFIER  = 13'h001;
   localparam logic [12:0] ADDR_GRADE    = 13'h002;
   localparam logic [12:0] ADDR_CHAN_SEL = 13'h005;
   localparam logic [12:0] ADDR_XFER     = 13'h0ff;
   localparam logic [12:0] ADDR_PROG_LO  = 13'h008;
   localparam logic [12:0] ADDR_PROG_HI  = 13'h018;
   localparam int          PROG_N        = 17;

   // ---------------------------------------------------------------
   // Program register layout
   // ---------------------------------------------------------------
   // Set bits mark present locations 0x08..0x18; 0x13 is absent.
   localparam logic [16:0] PROG_VALID    = 17'h1f7ff;
   // Set bits mark locations held once per channel (0x08, 0x10, 0x14, 0x16).
   localparam logic [16:0] PROG_LOCAL    = 17'h05101;
   localparam logic [4:0]  REF_SEL_IDX   = 5'h10;
   localparam logic [7:0]  REF_SEL_RST   = 8'he0;
   localparam logic [7:0]  PROG_RST      = 8'h00;

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int          CFG_LSB_HI    = 6;
   localparam int          CFG_LSB_LO    = 1;
   localparam int          CFG_SRST_HI   = 5;
   localparam int          CFG_SRST_LO   = 2;
   localparam logic [7:0]  PORT_CFG_RST  = 8'h18;
   localparam logic [1:0]  CHAN_SEL_RST  = 2'h3;
   localparam int          SEL_A         = 0;
   localparam int          SEL_B         = 1;
   localparam int          XFER_BIT      = 0;
   localparam int          GRADE_LSB     = 4;

   // ---------------------------------------------------------------
   // Frame timing
   // ---------------------------------------------------------------
   localparam logic [4:0]  INSTR_LAST    = 5'h0f;
   localparam logic [4:0]  BYTE_LAST     = 5'h07;

   // Frame phases.
   typedef enum logic [1:0] {
      ACFG_INSTR = 2'b01,
      ACFG_DATA  = 2'b10
   } acfg_phase_t;

endpackage

// ### logic/acfg_regbank.sv
// Serial-port configuration register bank of a dual-channel converter.
`timescale 1ns/1ps

// Overview of operation
// - Writes to 0x08..0x18 go to shadow copies, not to operation.
// - Writing 0x01 to 0xFF sets the transfer bit.
// - Transfer copies all shadows to active at once; bit then self-clears.
// - Local locations exist per channel; 0x05 bit 0 picks A, bit 1 B.
// - Both select bits set: a local write updates both channels.
// - Both select bits set on a read: channel A's copy returns.
// - Global locations have one copy and ignore channel select.
// - Any reset loads the documented default values.
// - Reference selection at 0x18 resets to 0xE0.
// - Map: config 0x00-0x02, index 0x05, transfer 0xFF, program 0x08-0x18.
// - Each local location has a separate physical copy per channel.

module acfg_regbank
   import acfg_pkg::*;
#(
   // Identifier value is arbitrary.
   parameter logic [7:0] CHIP_IDENTIFIER     = 8'h5a,
   parameter logic [2:0] SPEED_GRADE = 3'h0
) (
   // Core clock and power-on reset
   input  wire logic               clk_i,
   input  wire logic               arst_n_i,
   // Serial port pins
   input  wire logic               sclk_i,
   input  wire logic               csb_n_i,
   input  wire logic               sdio_i,
   output logic                    sdio_o,
   output logic                    sdio_oe_o,
   // Active program registers in the core domain
   output logic [PROG_N*8-1:0]     prog_a_o,
   output logic [PROG_N*8-1:0]     prog_b_o,
   output logic                    prog_update_o
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic                frame_rst_n;
   acfg_phase_t         phase_q;
   logic [4:0]          cnt_q;
   logic [15:0]         sh_q;
   logic                rd_q;
   logic [12:0]         addr_q;
   logic [7:0]          tx_q;
   logic                tx_bit_q;
   logic                tx_oe_q;

   logic                lsb_q;
   logic [1:0]          sel_q;
   logic                xfer_q;
   logic                xfer_tgl_q;
   logic [7:0]          shad_a_q [PROG_N];
   logic [7:0]          shad_b_q [PROG_N];
   logic [7:0]          act_a_q  [PROG_N];
   logic [7:0]          act_b_q  [PROG_N];

   logic [15:0]         instr_w;
   logic [7:0]          byte_w;
   logic                instr_done;
   logic                byte_done;
   logic                wr_en;
   logic [12:0]         next_addr;

   logic                tgl_sync;
   logic                tgl_seen_q;
   logic [PROG_N*8-1:0] prog_a_q;
   logic [PROG_N*8-1:0] prog_b_q;
   logic                upd_q;

   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------
   // Reverses a byte for LSB-first shifting.
   function automatic logic [7:0] rev8(input logic [7:0] v);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++) begin
         r[i] = v[7-i];
      end
      return r;
   endfunction

   // Reverses an instruction word for LSB-first shifting.
   function automatic logic [15:0] rev16(input logic [15:0] v);
      logic [15:0] r;
      r = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         r[i] = v[15-i];
      end
      return r;
   endfunction

   // True when the address is a present program location.
   function automatic logic is_prog(input logic [12:0] a);
      logic [12:0] off;
      off = a - ADDR_PROG_LO;
      return (a >= ADDR_PROG_LO) && (a <= ADDR_PROG_HI) && PROG_VALID[off[4:0]];
   endfunction

   // Program array index of an address.
   function automatic logic [4:0] prog_idx(input logic [12:0] a);
      logic [12:0] off;
      off = a - ADDR_PROG_LO;
      return off[4:0];
   endfunction

   // Default of a program location.
   function automatic logic [7:0] prog_rst(input int i);
      return (i == int'(REF_SEL_IDX)) ? REF_SEL_RST : PROG_RST;
   endfunction

   // Read value of an address, as seen by the host.
   function automatic logic [7:0] rd_val(input logic [12:0] a);
      logic [4:0] ix;
      logic [7:0] v;
      ix = prog_idx(a);
      v  = 8'h00;
      if (a == ADDR_PORT_CFG) begin
         v = {1'b0, lsb_q, 1'b0, 1'b1, 1'b1, 1'b0, lsb_q, 1'b0};
      end else if (a == ADDR_CHIP_IDENTIFIER) begin
         v = CHIP_IDENTIFIER;
      end else if (a == ADDR_GRADE) begin
         v = {1'b0, SPEED_GRADE, 4'h0};
      end else if (a == ADDR_CHAN_SEL) begin
         v = {6'h00, sel_q};
      end else if (a == ADDR_XFER) begin
         v = {7'h00, xfer_q};
      end else if (is_prog(a)) begin
         if (PROG_LOCAL[ix] && !sel_q[SEL_A] && sel_q[SEL_B]) begin
            v = shad_b_q[ix];
         end else begin
            v = shad_a_q[ix];
         end
      end
      return v;
   endfunction

   // ---------------------------------------------------------------
   // Frame decode
   // ---------------------------------------------------------------
   // Chip select high ends a frame and clears the frame state.
   assign frame_rst_n = arst_n_i & ~csb_n_i;

   // Words as they complete on this edge, in MSB-first order.
   assign instr_w    = lsb_q ? rev16({sh_q[14:0], sdio_i}) : {sh_q[14:0], sdio_i};
   assign byte_w     = lsb_q ? rev8({sh_q[6:0], sdio_i}) : {sh_q[6:0], sdio_i};
   assign instr_done = (phase_q == ACFG_INSTR) && (cnt_q == INSTR_LAST);
   assign byte_done  = (phase_q == ACFG_DATA) && (cnt_q == BYTE_LAST);
   assign wr_en      = byte_done && !rd_q;
   assign next_addr  = lsb_q ? addr_q + 13'h0001 : addr_q - 13'h0001;

   // Phase, bit count and address of the current frame.
   always_ff @(posedge sclk_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         phase_q <= ACFG_INSTR;
         cnt_q   <= 5'h00;
         rd_q    <= 1'b0;
         addr_q  <= 13'h0000;
      end else begin
         unique case (phase_q)
            ACFG_INSTR: begin
               if (instr_done) begin
                  phase_q <= ACFG_DATA;
                  cnt_q   <= 5'h00;
                  rd_q    <= instr_w[15];
                  addr_q  <= instr_w[12:0];
               end else begin
                  cnt_q <= cnt_q + 5'h01;
               end
            end
            ACFG_DATA: begin
               if (byte_done) begin
                  cnt_q  <= 5'h00;
                  addr_q <= next_addr;
               end else begin
                  cnt_q <= cnt_q + 5'h01;
               end
            end
         endcase
      end
   end

   // Input shift register.
   always_ff @(posedge sclk_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         sh_q <= 16'h0000;
      end else begin
         sh_q <= {sh_q[14:0], sdio_i};
      end
   end

   // Read byte, loaded at each byte boundary and shifted out MSB end first.
   always_ff @(posedge sclk_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         tx_q <= 8'h00;
      end else if (instr_done) begin
         tx_q <= lsb_q ? rev8(rd_val(instr_w[12:0])) : rd_val(instr_w[12:0]);
      end else if (byte_done) begin
         tx_q <= lsb_q ? rev8(rd_val(next_addr)) : rd_val(next_addr);
      end else begin
         tx_q <= {tx_q[6:0], 1'b0};
      end
   end

   // Output data changes on the falling edge, half a bit ahead of sampling.
   always_ff @(negedge sclk_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         tx_bit_q <= 1'b0;
         tx_oe_q  <= 1'b0;
      end else begin
         tx_bit_q <= tx_q[7];
         tx_oe_q  <= rd_q && (phase_q == ACFG_DATA);
      end
   end

   assign sdio_o    = tx_bit_q;
   assign sdio_oe_o = tx_oe_q;

   // ---------------------------------------------------------------
   // Configuration registers (serial clock domain)
   // ---------------------------------------------------------------
   // Port configuration, channel select and transfer bit.
   always_ff @(posedge sclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lsb_q  <= PORT_CFG_RST[CFG_LSB_HI];
         sel_q  <= CHAN_SEL_RST;
         xfer_q <= 1'b0;
      end else if (wr_en && addr_q == ADDR_PORT_CFG &&
                   (byte_w[CFG_SRST_HI] || byte_w[CFG_SRST_LO])) begin
         lsb_q  <= PORT_CFG_RST[CFG_LSB_HI];
         sel_q  <= CHAN_SEL_RST;
         xfer_q <= 1'b0;
      end else begin
         if (wr_en && addr_q == ADDR_PORT_CFG) begin
            lsb_q <= byte_w[CFG_LSB_HI] | byte_w[CFG_LSB_LO];
         end
         if (wr_en && addr_q == ADDR_CHAN_SEL) begin
            sel_q <= byte_w[1:0];
         end
         xfer_q <= wr_en && (addr_q == ADDR_XFER) && byte_w[XFER_BIT];
      end
   end

   // Shadow and active program registers.
   // Identifier and grade have no storage, so writes are dropped.
   always_ff @(posedge sclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < PROG_N; i++) begin
            shad_a_q[i] <= prog_rst(i);
            shad_b_q[i] <= prog_rst(i);
            act_a_q[i]  <= prog_rst(i);
            act_b_q[i]  <= prog_rst(i);
         end
         xfer_tgl_q <= 1'b0;
      end else if (wr_en && addr_q == ADDR_PORT_CFG &&
                   (byte_w[CFG_SRST_HI] || byte_w[CFG_SRST_LO])) begin
         for (int i = 0; i < PROG_N; i++) begin
            shad_a_q[i] <= prog_rst(i);
            shad_b_q[i] <= prog_rst(i);
            act_a_q[i]  <= prog_rst(i);
            act_b_q[i]  <= prog_rst(i);
         end
         xfer_tgl_q <= ~xfer_tgl_q;
      end else if (wr_en && addr_q == ADDR_XFER && byte_w[XFER_BIT]) begin
         for (int i = 0; i < PROG_N; i++) begin
            act_a_q[i] <= shad_a_q[i];
            act_b_q[i] <= shad_b_q[i];
         end
         xfer_tgl_q <= ~xfer_tgl_q;
      end else if (wr_en && is_prog(addr_q)) begin
         if (!PROG_LOCAL[prog_idx(addr_q)]) begin
            // Global single copy.
            // Both arrays take the byte, so a global reads the same on either output.
            shad_a_q[prog_idx(addr_q)] <= byte_w;
            shad_b_q[prog_idx(addr_q)] <= byte_w;
         end else begin
            if (sel_q[SEL_A]) begin
               shad_a_q[prog_idx(addr_q)] <= byte_w;
            end
            if (sel_q[SEL_B]) begin
               shad_b_q[prog_idx(addr_q)] <= byte_w;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Crossing to the core clock
   // ---------------------------------------------------------------
   // Active words are stable between transfers and soft resets; the toggle marks a change.
   acfg_sync u_tgl_sync (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .d_i      (xfer_tgl_q),
      .q_o      (tgl_sync)
   );

   // Captures the active words once the toggle has settled.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tgl_seen_q <= 1'b0;
         upd_q      <= 1'b0;
         for (int i = 0; i < PROG_N; i++) begin
            prog_a_q[i*8 +: 8] <= prog_rst(i);
            prog_b_q[i*8 +: 8] <= prog_rst(i);
         end
      end else begin
         tgl_seen_q <= tgl_sync;
         upd_q      <= tgl_sync ^ tgl_seen_q;
         if (tgl_sync ^ tgl_seen_q) begin
            for (int i = 0; i < PROG_N; i++) begin
               prog_a_q[i*8 +: 8] <= act_a_q[i];
               prog_b_q[i*8 +: 8] <= act_b_q[i];
            end
         end
      end
   end

   assign prog_a_o      = prog_a_q;
   assign prog_b_o      = prog_b_q;
   assign prog_update_o = upd_q;

endmodule

// ### logic/acfg_sync.sv
// Two flip-flop synchroniser for a single level.
`timescale 1ns/1ps

module acfg_sync (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic arst_n_i,
   // Level in and out
   input  wire logic d_i,
   output logic      q_o
);

   logic meta_q;
   logic sync_q;

   // First stage feeds only the second stage.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end

   assign q_o = sync_q;

endmodule

// ### tb/acfg_host_model.sv
// Serial host model that frames register reads and writes.
`timescale 1ns/1ps

module acfg_host_model (
   // Serial pins
   output logic      sclk_o,
   output logic      csb_n_o,
   output logic      sdio_o,
   input  wire logic sdio_i
);
   // ---------------------------------------------------------------
   // Frame tasks
   // ---------------------------------------------------------------
   // The clock rests low outside frames.
   // The select rises only once reset is low, so the frame logic sees its reset edge.
   initial begin
      sclk_o  = 1'b0;
      sdio_o  = 1'b0;
      #2 csb_n_o = 1'b1;
   end

   // One 30 ns bit: data set on the fall, sampled on the rise.
   task automatic bit_cyc(input logic b, output logic r);
      sdio_o = b;
      #15 sclk_o = 1'b1;
      r = sdio_i;
      #15 sclk_o = 1'b0;
   endtask

   // First byte in the upper byte of w and d when n is two.
   task automatic xfer(input logic rd, input logic [12:0] adr, input int n,
                       input logic [15:0] w, input logic lsb, output logic [15:0] d);
      logic [15:0] ins;
      logic        r;
      int          idx;
      ins = {rd, 2'b00, adr};
      d = 16'h0000;
      csb_n_o = 1'b0;
      #15;
      for (int k = 0; k < 16; k++) bit_cyc(ins[lsb ? k : 15 - k], r);
      for (int k = 0; k < 8 * n; k++) begin
         idx = (n - 1 - k / 8) * 8 + (lsb ? k % 8 : 7 - k % 8);
         if (rd) bit_cyc(~sdio_o, r);
         else bit_cyc(w[idx], r);
         d[idx] = r;
      end
      #15 csb_n_o = 1'b1;
      sdio_o = ~sdio_o;
      #45;
   endtask
endmodule

// ### tb/acfg_regbank_checker.sv
// Port checker for the configuration register bank.
`timescale 1ns/1ps

module acfg_regbank_checker
   import acfg_pkg::*;
(
   // Core clock, reset and serial pins
   input wire logic                clk_i,
   input wire logic                arst_n_i,
   input wire logic                sclk_i,
   input wire logic                csb_n_i,
   input wire logic                sdio_i,
   input wire logic                sdio_o,
   input wire logic                sdio_oe_o,
   // Active program registers
   input wire logic [PROG_N*8-1:0] prog_a_o,
   input wire logic [PROG_N*8-1:0] prog_b_o,
   input wire logic                prog_update_o
);
   // ---------------------------------------------------------------
   // Helper logic
   // ---------------------------------------------------------------
   logic [4:0]          cnt_q;
   logic                rd_q;
   logic [PROG_N*8-1:0] glob_mask;

   // Marks the bytes that exist once for both channels.
   always_comb begin
      for (int i = 0; i < PROG_N; i++) begin
         glob_mask[i*8+:8] = PROG_LOCAL[i] ? 8'h00 : 8'hff;
      end
   end

   // Counts frame rises up to 17 and keeps the first bit as direction.
   always_ff @(posedge sclk_i or posedge csb_n_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_q <= 5'h00;
         rd_q  <= 1'b0;
      end else if (csb_n_i) begin
         cnt_q <= 5'h00;
      end else begin
         if (cnt_q == 5'h00) rd_q <= sdio_i;
         if (cnt_q != 5'h11) cnt_q <= cnt_q + 5'h01;
      end
   end

   // A read frame one bit past its instruction.
   sequence s_read_turn;
      (cnt_q == 5'h11) && rd_q;
   endsequence

   a_idle_oe: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      csb_n_i && $past(csb_n_i) |-> !sdio_oe_o) else $error("sdio driven while idle");
   a_no_drive_write: assert property (@(negedge sclk_i) disable iff (!arst_n_i)
      (cnt_q < 5'h10 || !rd_q) |-> !sdio_oe_o) else $error("sdio driven outside read");
   a_drive_on_read: assert property (@(negedge sclk_i) disable iff (!arst_n_i)
      s_read_turn |-> sdio_oe_o) else $error("sdio not driven in read data");
   a_update_single: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      prog_update_o |=> !prog_update_o [*8]) else $error("update pulse too long");
   a_prog_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      $changed(prog_a_o) || $changed(prog_b_o) |-> ##[0:1] prog_update_o)
      else $error("active registers moved without update");
   a_global_match: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      ((prog_a_o ^ prog_b_o) & glob_mask) == '0) else $error("global byte differs");
   a_absent_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      prog_a_o[95:88] == 8'h00 && prog_b_o[95:88] == 8'h00) else $error("absent byte set");
endmodule

bind acfg_regbank acfg_regbank_checker u_chk (
   .clk_i(clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk_i), .csb_n_i(csb_n_i),
   .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o), .prog_a_o(prog_a_o),
   .prog_b_o(prog_b_o), .prog_update_o(prog_update_o));

// ### tb/tb_acfg_regbank.sv
// Self-checking bench for the configuration register bank.
`timescale 1ns/1ps

module tb_acfg_regbank;
   import acfg_pkg::*;
   // Identifier value is arbitrary.
   localparam logic [7:0] ID_V = 8'h3c;
   localparam logic [2:0] GR_V = 3'h2;

   // ---------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------
   logic                clk_i, arst_n_i, lsb_m;
   logic                sclk, csb_n, sdio_h, sdio_d, sdio_oe, upd;
   logic [PROG_N*8-1:0] pa_w, pb_w;
   wire logic           sdio_w;
   int                  num_checks, bad_count;

   // The pin shows the device only while it drives.
   assign sdio_w = sdio_oe ? sdio_d : sdio_h;

   acfg_regbank #(.CHIP_IDENTIFIER(ID_V), .SPEED_GRADE(GR_V)) u_acfg_regbank (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk), .csb_n_i(csb_n),
      .sdio_i(sdio_w), .sdio_o(sdio_d), .sdio_oe_o(sdio_oe), .prog_a_o(pa_w),
      .prog_b_o(pb_w), .prog_update_o(upd));
   acfg_host_model u_host (.sclk_o(sclk), .csb_n_o(csb_n), .sdio_o(sdio_h), .sdio_i(sdio_w));

   // Core clock of 25 ns.
   always #12.5 clk_i = ~clk_i;

   function automatic logic [7:0] pa(int i); return pa_w[i*8+:8]; endfunction
   function automatic logic [7:0] pb(int i); return pb_w[i*8+:8]; endfunction

   task automatic close_out();
      $display("Checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [12:0] a, input logic [7:0] w);
      logic [15:0] d;
      u_host.xfer(1'b0, a, 1, {8'h00, w}, lsb_m, d);
   endtask

   task automatic rdc(input logic [12:0] a, input logic [7:0] e);
      logic [15:0] d;
      u_host.xfer(1'b1, a, 1, 16'h0000, lsb_m, d);
      chk(d[7:0], e);
   endtask

   // Bounded wait for one update pulse.
   task automatic wait_upd();
      int i;
      for (i = 0; i < 60 && upd !== 1'b1; i++) begin
         @(posedge clk_i);
         #1;
      end
      chk({7'h00, upd}, 8'h01);
      if (upd !== 1'b1) close_out();
   endtask

   task automatic xfer_now();
      fork
         wr(ADDR_XFER, 8'h01);
         wait_upd();
      join
   endtask

   task automatic t_defaults();
      for (int i = 0; i < PROG_N; i++) chk(pb(i), i == 16 ? 8'he0 : 8'h00);
      rdc(ADDR_PORT_CFG, 8'h18);
      rdc(ADDR_CHIP_IDENTIFIER, ID_V);
      rdc(ADDR_GRADE, {1'b0, GR_V, 4'h0});
   endtask

   task automatic t_readonly();
      wr(ADDR_CHIP_IDENTIFIER, 8'hff);
      wr(ADDR_GRADE, 8'h70);
      // The absent location 0x13 is only ever read, never written.
      rdc(ADDR_CHIP_IDENTIFIER, ID_V);
      rdc(ADDR_GRADE, {1'b0, GR_V, 4'h0});
      rdc(13'h013, 8'h00);
   endtask

   task automatic t_shadow();
      wr(13'h009, 8'h01);
      repeat (40) @(posedge clk_i);
      chk(pa(1), 8'h00);
      rdc(13'h009, 8'h01);
      xfer_now();
      chk(pa(1), 8'h01);
      chk(pb(1), 8'h01);
      rdc(ADDR_XFER, 8'h00);
   endtask

   task automatic t_local();
      wr(ADDR_CHAN_SEL, 8'h01);
      wr(13'h008, 8'h20);
      wr(ADDR_CHAN_SEL, 8'h02);
      wr(13'h008, 8'h40);
      wr(ADDR_CHAN_SEL, 8'h03);
      wr(13'h010, 8'h11);
      xfer_now();
      chk(pa(0), 8'h20);
      chk(pb(0), 8'h40);
      chk(pb(8), 8'h11);
      rdc(13'h008, 8'h20);
      wr(ADDR_CHAN_SEL, 8'h02);
      rdc(13'h008, 8'h40);
   endtask

   task automatic t_stream();
      logic [15:0] d;
      u_host.xfer(1'b0, 13'h009, 2, 16'h0060, 1'b0, d);
      u_host.xfer(1'b1, 13'h009, 2, 16'h0000, 1'b0, d);
      chk(d[15:8], 8'h00);
      chk(d[7:0], 8'h60);
   endtask

   task automatic t_lsb_soft();
      wr(ADDR_PORT_CFG, 8'h42);
      lsb_m = 1'b1;
      wr(13'h010, 8'h0f);
      wr(ADDR_PORT_CFG, 8'h18);
      lsb_m = 1'b0;
      rdc(13'h010, 8'h0f);
      fork
         wr(ADDR_PORT_CFG, 8'h3c);
         wait_upd();
      join
      chk(pa(16), 8'he0);
      chk(pb(0), 8'h00);
      rdc(13'h009, 8'h00);
   endtask

   // Reset for two cycles, then every scenario in turn.
   initial begin
      clk_i = 1'b0;
      // Reset falls just after time zero, so every reset edge is seen.
      arst_n_i = 1'b1;
      #1 arst_n_i = 1'b0;
      lsb_m = 1'b0;
      num_checks = 0;
      bad_count = 0;
      repeat (2) @(posedge clk_i);
      #2 arst_n_i = 1'b1;
      t_defaults();
      t_readonly();
      t_shadow();
      t_local();
      t_stream();
      t_lsb_soft();
      close_out();
   end
endmodule
